// ---- include/spib_regs.vh ----
// register offsets, field positions and reset values of the spi buffer block
`ifndef SPIB_REGS_VH
`define SPIB_REGS_VH
`define SPIB_ADDR_CTRL 3'h1
`define SPIB_ADDR_FLAGS 3'h3
`define SPIB_ADDR_DATA 3'h4
`define SPIB_CTRL_BUFMODE_BIT 7
`define SPIB_CTRL_SSDIS_BIT 2
`define SPIB_CTRL_MASTER_BIT 5
`define SPIB_CTRL_CLKDIV_LSB 0
`define SPIB_FLAG_RXC_BIT 7
`define SPIB_FLAG_TXC_BIT 6
`define SPIB_FLAG_DRE_BIT 5
`define SPIB_FLAG_SSTRIG_BIT 4
`define SPIB_FLAG_OVF_BIT 0
`define SPIB_RESET_BYTE 8'h00
`define SPIB_SCK_HALF 4'h4
`endif

// ---- hdl/spib_buf2.v ----
// two-entry valid/ready buffer
`timescale 1ns/10ps
module spib_buf2 (
    input wire clk,
    input wire rst,
    input wire [7:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [7:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [7:0] slot0;
    reg [7:0] slot1;
    reg [1:0] count;
    wire push;
    wire pop;
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = slot0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge clk) begin
        if (rst) begin
            count <= 2'h0;
            slot0 <= 8'h00;
            slot1 <= 8'h00;
        end else begin
            if (pop) begin
                slot0 <= slot1;
            end
            if (push) begin
                if (count == 2'h0 || (count == 2'h1 && pop)) begin
                    slot0 <= in_data;
                end else begin
                    slot1 <= in_data;
                end
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // spib_buf2

// ---- hdl/spib_core.v ----
// spi data register, two-deep receive buffer and buffer-mode flags
`timescale 1ns/10ps
`include "spib_regs.vh"
module spib_core (
    input wire clk,
    input wire rst,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    input wire ss_n_in,
    input wire sck_in,
    input wire mosi_in,
    input wire miso_in,
    output reg sck_out,
    output reg sck_oe,
    output reg mosi_out,
    output reg mosi_oe,
    output reg miso_out,
    output reg miso_oe,
    output reg master_mode,
    output reg busy
);
    localparam ST_IDLE = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_DONE = 2'h2;

    reg [7:0] ctrl;
    reg ss_trig;
    reg ovf;
    reg ovf_pend;
    reg txc;
    reg [7:0] tx_hold;
    reg tx_full;
    reg [7:0] shreg;
    reg rx_bit;
    reg [2:0] bitcnt;
    reg [1:0] state;
    reg [3:0] divcnt;
    reg sck_int;
    reg [7:0] nb_data;
    // synchronisers: first stage read by second only
    reg ss_m;
    reg ss_s;
    reg ss_d;
    reg sck_m;
    reg sck_s;
    reg sck_d;
    reg mosi_m;
    reg mosi_s;
    reg miso_m;
    reg miso_s;

    wire buf_mode = ctrl[`SPIB_CTRL_BUFMODE_BIT];
    wire ss_disable = ctrl[`SPIB_CTRL_SSDIS_BIT];
    wire half_end = (divcnt == `SPIB_SCK_HALF);
    wire wr_data = wr_en && addr == `SPIB_ADDR_DATA;
    wire rd_data = rd_en && addr == `SPIB_ADDR_DATA;
    wire wr_flags = wr_en && addr == `SPIB_ADDR_FLAGS;
    wire wr_ctrl = wr_en && addr == `SPIB_ADDR_CTRL;
    wire ss_fall = ss_d && !ss_s;
    wire sck_rise = sck_s && !sck_d;
    wire sck_fall = !sck_s && sck_d;
    wire ss_active = !ss_s;
    wire byte_done;
    wire start_tx;
    wire [7:0] rx_top;
    wire rx_top_valid;
    wire rx_in_ready;
    wire [7:0] rx_in_data = {shreg[6:0], master_mode ? miso_s : mosi_s};
    wire ss_force = master_mode && ss_fall && !ss_disable;

    spib_buf2 i_spib_buf2 (
        .clk(clk),
        .rst(rst),
        .in_data(rx_in_data),
        .in_valid(byte_done && buf_mode),
        .in_ready(rx_in_ready),
        .out_data(rx_top),
        .out_valid(rx_top_valid),
        .out_ready(rd_data && buf_mode)
    );

    // last bit taken straight from the pin sampler
    assign byte_done = (state == ST_SHIFT) && bitcnt == 3'h7
        && (master_mode ? (half_end && sck_int == 1'b0) : sck_rise);
    // a selected slave is ready to receive with nothing queued
    // as master, a data write starts a transfer
    assign start_tx = (state == ST_IDLE) && (master_mode ? tx_full : ss_active);

    // two flops cost two cycles on every pin; fine at this link rate

    always @(posedge clk) begin
        ss_m <= ss_n_in;
        ss_s <= ss_m;
        ss_d <= ss_s;
        sck_m <= sck_in;
        sck_s <= sck_m;
        sck_d <= sck_s;
        mosi_m <= mosi_in;
        mosi_s <= mosi_m;
        miso_m <= miso_in;
        miso_s <= miso_m;
    end

    always @(posedge clk) begin
        if (rst) begin
            ctrl <= 8'h00;
            master_mode <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wdata;
                master_mode <= wdata[`SPIB_CTRL_MASTER_BIT];
            end else if (ss_force) begin
                master_mode <= 1'b0;
            end
        end
    end

    // trigger flag
    always @(posedge clk) begin
        if (rst) begin
            ss_trig <= 1'b0;
        end else if (!buf_mode) begin
            ss_trig <= 1'b0;
        end else if (ss_force) begin
            ss_trig <= 1'b1;
        end else if (wr_flags && wdata[`SPIB_FLAG_SSTRIG_BIT]) begin
            ss_trig <= 1'b0;
        end
    end

    // overflow flag and its deferred form
    always @(posedge clk) begin
        if (rst) begin
            ovf <= 1'b0;
            ovf_pend <= 1'b0;
        end else if (!buf_mode) begin
            ovf <= 1'b0;
            ovf_pend <= 1'b0;
        end else if (byte_done && !rx_in_ready) begin
            if (tx_full) begin
                ovf <= 1'b1;
            end else begin
                ovf_pend <= 1'b1;
            end
        end else if (ovf_pend && start_tx) begin
            ovf <= 1'b1;
            ovf_pend <= 1'b0;
        // cleared by data read; an overrun in the same cycle wins
        end else if (rd_data) begin
            ovf <= 1'b0;
            ovf_pend <= 1'b0;
        end
    end

    // tx complete, set only when nothing waits behind the byte
    always @(posedge clk) begin
        if (rst) begin
            txc <= 1'b0;
        end else if (!buf_mode) begin
            txc <= 1'b0;
        end else if (byte_done && !tx_full) begin
            txc <= 1'b1;
        end else if (wr_flags && wdata[`SPIB_FLAG_TXC_BIT]) begin
            txc <= 1'b0;
        end
    end

    // transmit holding entry, a late write overwrites it
    always @(posedge clk) begin
        if (rst) begin
            tx_hold <= `SPIB_RESET_BYTE;
            tx_full <= 1'b0;
        end else if (wr_data) begin
            tx_hold <= wdata;
            tx_full <= 1'b1;
        end else if (start_tx) begin
            tx_full <= 1'b0;
        end
    end

    // transfer sequencing
    always @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            busy <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_tx) begin
                        busy <= 1'b1;
                        state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    // a control write or a slave deselect ends the frame
                    if (wr_ctrl || (!master_mode && !ss_active)) begin
                        busy <= 1'b0;
                        state <= ST_IDLE;
                    end else if (byte_done) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // last high phase runs its full length before idle
                    if (!master_mode || half_end) begin
                        busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // mode 0 only; runs only in a frame, so sck rests low between frames
    always @(posedge clk) begin
        if (rst) begin
            divcnt <= 4'h0;
            sck_int <= 1'b0;
        end else if (state == ST_IDLE || !master_mode) begin
            divcnt <= 4'h0;
            sck_int <= 1'b0;
        end else if (half_end) begin
            divcnt <= 4'h0;
            sck_int <= !sck_int;
        end else begin
            divcnt <= divcnt + 4'h1;
        end
    end

    // shifter: master samples on rise and shifts on fall
    always @(posedge clk) begin
        if (rst) begin
            shreg <= `SPIB_RESET_BYTE;
            rx_bit <= 1'b0;
            bitcnt <= 3'h0;
            nb_data <= `SPIB_RESET_BYTE;
        end else if (state == ST_IDLE) begin
            if (start_tx) begin
                shreg <= tx_hold;
                bitcnt <= 3'h0;
            end
        end else if (state == ST_SHIFT) begin
            if (master_mode) begin
                if (half_end && !sck_int) begin
                    rx_bit <= rx_in_data[0];
                end else if (half_end) begin
                    // mosi moves away from the far side's sampling edge
                    shreg <= {shreg[6:0], rx_bit};
                    bitcnt <= bitcnt + 3'h1;
                end
            end else if (sck_rise) begin
                shreg <= rx_in_data;
                bitcnt <= bitcnt + 3'h1;
            end
            if (byte_done && !buf_mode) begin
                nb_data <= rx_in_data;
            end
        end
    end

    // pin drivers, msb first
    always @(posedge clk) begin
        if (rst) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            sck_out <= sck_int;
            sck_oe <= master_mode;
            mosi_out <= shreg[7];
            // mosi released as slave so the far master owns it
            mosi_oe <= master_mode;
            miso_out <= shreg[7];
            // slave drives miso only while selected
            miso_oe <= !master_mode && ss_active;
        end
    end

    // read data, one cycle after strobe
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `SPIB_ADDR_CTRL: rdata <= ctrl;
                `SPIB_ADDR_FLAGS: rdata <= {buf_mode && rx_top_valid, txc,
                    buf_mode && !tx_full, ss_trig, 3'h0, ovf};
                `SPIB_ADDR_DATA: rdata <= buf_mode ? rx_top : nb_data;
                // unmapped indices read zero
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end
endmodule // spib_core

// ---- verification/spib_core_monitor.sv ----
// assertion checker bound to the spi buffer core
`timescale 1ns/10ps
module spib_core_monitor (
    input wire clk,
    input wire rst,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rdata,
    input wire ss_n_in,
    input wire sck_out,
    input wire sck_oe,
    input wire mosi_oe,
    input wire master_mode,
    input wire busy
);
    // shadow of control, the checker cannot see inside
    reg [7:0] ctrl;
    always @(posedge clk) begin
        if (rst)
            ctrl <= 8'h00;
        else if (wr_en && addr == 3'h1)
            ctrl <= wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_RD_QUIET: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    AST_RD_UNMAPPED: assert property (rd_en && addr == 3'h0 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    // sync delay of slave select is two flops
    AST_SS_SLAVE: assert property ((!ss_n_in && !ctrl[2] && !wr_en) [*5] |-> !master_mode)
        else $error("slave select low did not end master role");
    AST_SSD_HOLD: assert property (master_mode && ctrl[2] && !(wr_en && addr == 3'h1)
        |=> master_mode)
        else $error("master role lost with select disabled");
    AST_FLAGS_OFF: assert property (rd_en && addr == 3'h3 && !ctrl[7]
        |=> rdata[4] == 1'b0 && rdata[0] == 1'b0)
        else $error("buffer flags set outside buffer mode");
    AST_SCK_HALF: assert property ($rose(sck_out)
        |=> $stable(sck_out) [*4] ##1 $fell(sck_out))
        else $error("serial clock high time not five cycles");
    AST_BUSY_GO: assert property (wr_en && addr == 3'h4 && master_mode && !busy
        |-> ##[1:3] busy)
        else $error("data write did not start a transfer");
    AST_OE_MASTER: assert property ($rose(master_mode) |-> ##[0:1] (sck_oe && mosi_oe))
        else $error("master pins not driven");
endmodule // spib_core_monitor
bind spib_core spib_core_monitor i_spib_core_monitor (.clk, .rst, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .ss_n_in, .sck_out, .sck_oe, .mosi_oe, .master_mode, .busy);

// ---- verification/spib_slave_model.sv ----
// far-side spi slave model, mode 0, msb first
`timescale 1ns/10ps
module spib_slave_model (
    input wire sck,
    input wire mosi,
    input wire [7:0] reply,
    output wire miso,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    logic [2:0] cnt = 3'h0;
    // always selected, so miso never floats
    assign miso = reply[3'h7 - cnt];
    always @(posedge sck) sh <= {sh[6:0], mosi};
    always @(negedge sck) begin
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7)
            got <= sh;
    end
endmodule // spib_slave_model

// ---- verification/spib_core_test.sv ----
// self-checking bench of the spi buffer core
`timescale 1ns/10ps
module spib_core_test;
    logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, ss_n_in = 1, sck_tb = 0, mosi_tb = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, reply = 8'h00, d;
    wire [7:0] rdata, got;
    wire sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, master_mode, busy, miso;
    // pin levels resolved from the output enables
    wire sck_w = sck_oe ? sck_out : sck_tb;
    wire mosi_w = mosi_oe ? mosi_out : mosi_tb;
    wire miso_w = miso_oe ? miso_out : miso;
    int err_count = 0, n_checks = 0;
    always #12.5 clk = ~clk;
    spib_core i_spib_core (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .ss_n_in(ss_n_in), .sck_in(sck_w), .mosi_in(mosi_w),
        .miso_in(miso_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
        .master_mode(master_mode), .busy(busy));
    spib_slave_model i_spib_slave_model (.sck(sck_w), .mosi(mosi_w), .reply(reply),
        .miso(miso), .got(got));
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task xfer(input logic [7:0] v, input logic [7:0] r);
        int n;
        n = 0;
        reply <= r;
        wr(3'h4, v);
        repeat (4) @(posedge clk);
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(posedge clk);
        chk(got, v);
    endtask
    // external master at a 200 ns link clock
    task slv(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            mosi_tb <= v[i];
            repeat (4) @(posedge clk);
            sck_tb <= 1'b1;
            repeat (4) @(posedge clk);
            sck_tb <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask
    task ss_low(input logic [7:0] c);
        wr(3'h1, c);
        ss_n_in <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task t_reset;
        rd(3'h4);
        chk(d, 8'h00);
        wr(3'h0, 8'hff);
        rd(3'h0);
        chk(d, 8'h00);
    endtask
    task t_ss;
        ss_low(8'ha0);
        chk(master_mode, 8'h00);
        chk(miso_oe, 8'h01);
        rd(3'h3);
        chk(d[4], 8'h01);
        wr(3'h3, 8'h00);
        rd(3'h3);
        chk(d[4], 8'h01);
        wr(3'h3, 8'h10);
        rd(3'h3);
        chk(d[4], 8'h00);
        slv(8'hc3);
        rd(3'h4);
        chk(d, 8'hc3);
        ss_n_in <= 1'b1;
    endtask
    task t_ssd;
        ss_low(8'ha4);
        chk(master_mode, 8'h01);
        rd(3'h3);
        chk(d[4], 8'h00);
        ss_n_in <= 1'b1;
    endtask
    task t_nobuf;
        ss_low(8'h20);
        rd(3'h3);
        chk({d[4], d[0]}, 8'h00);
        ss_n_in <= 1'b1;
    endtask
    task t_master;
        wr(3'h1, 8'ha0);
        xfer(8'h96, 8'h3c);
        xfer(8'h69, 8'h5a);
        // third byte with nothing queued behind it
        xfer(8'h01, 8'h11);
        rd(3'h3);
        chk(d[0], 8'h00);
        xfer(8'h02, 8'h22);
        rd(3'h3);
        chk(d[0], 8'h01);
        wr(3'h3, 8'h00);
        rd(3'h3);
        chk(d[0], 8'h01);
        rd(3'h4);
        chk(d, 8'h3c);
        rd(3'h3);
        chk(d[0], 8'h00);
        rd(3'h4);
        chk(d, 8'h5a);
    endtask
    task test_done;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_ss;
        t_ssd;
        t_nobuf;
        t_master;
        test_done;
    end
    initial begin
        #200000;
        err_count++;
        test_done;
    end
endmodule // spib_core_test
